// File: hw/bic_defs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * board interrupt control block.
 * Assumes a 10 MHz system clock and byte addresses on an Avalon-MM bus.
 */
`ifndef BIC_DEFS_SVH
`define BIC_DEFS_SVH

`define BIC_OFS_OPTIONS      8'h04
`define BIC_OFS_LOCATOR      8'h08
`define BIC_OFS_EN_LO        8'h10
`define BIC_OFS_EN_HI        8'h14
`define BIC_OFS_PEND_LO      8'h20
`define BIC_OFS_PEND_HI      8'h24
`define BIC_OFS_CLR_LO       8'h30
`define BIC_OFS_CLR_HI       8'h34
`define BIC_OFS_ARM_LO       8'h40
`define BIC_OFS_ARM_HI       8'h44
`define BIC_OFS_LVL_LO       8'h50
`define BIC_OFS_LVL_HI       8'h54
`define BIC_OFS_POL_LO       8'h60
`define BIC_OFS_POL_HI       8'h64
`define BIC_OFS_ROUTE0       8'h70
`define BIC_OFS_ROUTE1       8'h74
`define BIC_OFS_ROUTE2       8'h78
`define BIC_OFS_STATUS       8'h80
`define BIC_OFS_MASK         8'h84

`define BIC_LOC_IDENT_BIT    7
`define BIC_PEND_SUMMARY_BIT 16
`define BIC_ROUTE_FLD_W      6
`define BIC_ROUTE_FLD_STRIDE 8
`define BIC_SRC_VALID        64'hffff_ffff_fffe_ffff

`define BIC_MASK_RST         2'h3
`define BIC_WORD_RST         32'h0000_0000
`define BIC_FW_INFO_RST      32'h0000_0000

`define BIC_CLK_NS           100
`define BIC_BLINK_HALF_NS    500000000
`define BIC_BLINK_HALF_CYC   (`BIC_BLINK_HALF_NS / `BIC_CLK_NS)

`endif

// File: hw/bic_pkg.sv
/*
 * Types shared by the board interrupt control block and its bus master.
 * Assumes the constants of bic_defs.svh.
 */
package bic_pkg;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } bic_av_req_t;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } bic_av_rsp_t;

    typedef struct packed {
        logic [63:0]      en;
        logic [63:0]      pend;
        logic [63:0]      arm;
        logic [63:0]      lvl;
        logic [63:0]      pol;
        logic [63:0]      prev;
        logic [2:0][31:0] route;
        logic [31:0]      locator;
        logic [1:0]       stat;
        logic [1:0]       mask;
        logic [22:0]      blink_cnt;
        logic             blink_ph;
        logic             wait_rq;
        logic [31:0]      rdata;
        logic             irq;
        logic [11:0]      ext;
        logic             led_red;
        logic             led_green;
    } bic_state_t;

endpackage : bic_pkg

// File: hw/bic_irq_ctrl.sv
/*
 * Interrupt control registers of the timing board: enable, request,
 * pending, clear, arm, level and polarity per source, external routing,
 * board locator blink and the option word, behind an Avalon-MM slave.
 * Assumes source inputs are synchronous to clk_sys_i.
 */
// What this block does
// - While locator bit 7 is set, LEDs alternate red and green once a second.
// - Clearing locator bit 7 stops blinking and restores normal LED use.
// - A source counts as active only when its enable bit is set.
// - Writing a request bit raises that source's request in software.
// - Pending registers show each outstanding request, one bit per source.
// - Writing a clear bit removes that source's outstanding request.
// - Edge-triggered sources catch an edge only while their arm bit is set.
// - Level bit 1 selects level sensing, 0 selects edge detection.
// - Polarity bit 1 means high or rising, 0 means low or falling.
// - Pending word one bit 16 reads 1 when word two has nothing pending.
// - Each external output follows the enabled pending bit of the source chosen by the routing registers.
// - A read-only word reports fitted options and firmware revision.
`timescale 1ns/1ps
`include "bic_defs.svh"

module bic_irq_ctrl #(
    parameter int          BLINK_HALF_CYC = `BIC_BLINK_HALF_CYC,
    parameter logic [31:0] FW_INFO        = `BIC_FW_INFO_RST  // Arbitrary value.
) (
    input  wire logic                 clk_sys_i,
    input  wire logic                 reset_n_i,
    input  wire bic_pkg::bic_av_req_t bus_req_i,
    output wire bic_pkg::bic_av_rsp_t bus_rsp_o,
    input  wire logic [63:0]          src_i,
    output logic                      host_irq_o,
    output logic [11:0]               ext_irq_o,
    output logic                      led_red_o,
    output logic                      led_green_o
);
    import bic_pkg::*;

    localparam logic [22:0] BLINK_LAST = 23'(BLINK_HALF_CYC - 1);
    localparam logic [63:0] SRC_VALID  = `BIC_SRC_VALID;

    bic_state_t  q_ff;
    bic_state_t  nxt_q;
    logic        req;
    logic        take;
    logic [31:0] wmask;
    logic [63:0] act;
    logic [63:0] hw_hit;
    logic [63:0] sw_set;
    logic [63:0] sw_clr;
    logic [1:0]  stat_w1c;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction : merge

    assign req   = bus_req_i.read | bus_req_i.write;
    assign take  = req & ~q_ff.wait_rq;
    assign wmask = {{8{bus_req_i.byteenable[3]}}, {8{bus_req_i.byteenable[2]}},
                    {8{bus_req_i.byteenable[1]}}, {8{bus_req_i.byteenable[0]}}};
    assign act   = q_ff.pend & q_ff.en;

    ////////////////////////////////////////////////////////////////////////////

    // Source detection: level sources match polarity, edge sources need arm.
    always_comb begin
        logic [63:0] rise;
        logic [63:0] fall;
        rise   = src_i & ~q_ff.prev;
        fall   = ~src_i & q_ff.prev;
        hw_hit = SRC_VALID & ((q_ff.lvl & ~(src_i ^ q_ff.pol))
               | (~q_ff.lvl & q_ff.arm
                  & ((q_ff.pol & rise) | (~q_ff.pol & fall))));
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (bus_req_i.address)
            `BIC_OFS_OPTIONS: rd_mux = FW_INFO;
            `BIC_OFS_LOCATOR: rd_mux = q_ff.locator;
            `BIC_OFS_EN_LO:   rd_mux = q_ff.en[31:0];
            `BIC_OFS_EN_HI:   rd_mux = q_ff.en[63:32];
            `BIC_OFS_PEND_LO: begin
                rd_mux = q_ff.pend[31:0];
                rd_mux[`BIC_PEND_SUMMARY_BIT] = ~|q_ff.pend[63:32];
            end
            `BIC_OFS_PEND_HI: rd_mux = q_ff.pend[63:32];
            `BIC_OFS_ARM_LO:  rd_mux = q_ff.arm[31:0];
            `BIC_OFS_ARM_HI:  rd_mux = q_ff.arm[63:32];
            `BIC_OFS_LVL_LO:  rd_mux = q_ff.lvl[31:0];
            `BIC_OFS_LVL_HI:  rd_mux = q_ff.lvl[63:32];
            `BIC_OFS_POL_LO:  rd_mux = q_ff.pol[31:0];
            `BIC_OFS_POL_HI:  rd_mux = q_ff.pol[63:32];
            `BIC_OFS_ROUTE0:  rd_mux = q_ff.route[0] & 32'h3f3f_3f3f;
            `BIC_OFS_ROUTE1:  rd_mux = q_ff.route[1] & 32'h3f3f_3f3f;
            `BIC_OFS_ROUTE2:  rd_mux = q_ff.route[2] & 32'h3f3f_3f3f;
            `BIC_OFS_STATUS:  rd_mux = {30'h0000_0000, q_ff.stat};
            `BIC_OFS_MASK:    rd_mux = {30'h0000_0000, q_ff.mask};
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        logic [5:0] sel;
        sel      = 6'h00;
        nxt_q    = q_ff;
        sw_set   = 64'h0000_0000_0000_0000;
        sw_clr   = 64'h0000_0000_0000_0000;
        stat_w1c = 2'h0;

        // One wait state: data is fetched while waitrequest is high and the
        // write lands on the edge where the master sees waitrequest low.
        nxt_q.wait_rq = 1'b1;
        if (req && q_ff.wait_rq) begin
            nxt_q.wait_rq = 1'b0;
            nxt_q.rdata   = bus_req_i.read ? rd_mux : 32'h0000_0000;
        end

        if (take && bus_req_i.write) begin
            unique case (bus_req_i.address)
                `BIC_OFS_LOCATOR: nxt_q.locator =
                                      merge(q_ff.locator, bus_req_i.writedata, wmask);
                `BIC_OFS_EN_LO:   nxt_q.en[31:0] =
                                      merge(q_ff.en[31:0], bus_req_i.writedata, wmask);
                `BIC_OFS_EN_HI:   nxt_q.en[63:32] =
                                      merge(q_ff.en[63:32], bus_req_i.writedata, wmask);
                `BIC_OFS_PEND_LO: sw_set[31:0] = bus_req_i.writedata & wmask;
                `BIC_OFS_PEND_HI: sw_set[63:32] = bus_req_i.writedata & wmask;
                `BIC_OFS_CLR_LO:  sw_clr[31:0] = bus_req_i.writedata & wmask;
                `BIC_OFS_CLR_HI:  sw_clr[63:32] = bus_req_i.writedata & wmask;
                `BIC_OFS_ARM_LO:  nxt_q.arm[31:0] =
                                      merge(q_ff.arm[31:0], bus_req_i.writedata, wmask);
                `BIC_OFS_ARM_HI:  nxt_q.arm[63:32] =
                                      merge(q_ff.arm[63:32], bus_req_i.writedata, wmask);
                `BIC_OFS_LVL_LO:  nxt_q.lvl[31:0] =
                                      merge(q_ff.lvl[31:0], bus_req_i.writedata, wmask);
                `BIC_OFS_LVL_HI:  nxt_q.lvl[63:32] =
                                      merge(q_ff.lvl[63:32], bus_req_i.writedata, wmask);
                `BIC_OFS_POL_LO:  nxt_q.pol[31:0] =
                                      merge(q_ff.pol[31:0], bus_req_i.writedata, wmask);
                `BIC_OFS_POL_HI:  nxt_q.pol[63:32] =
                                      merge(q_ff.pol[63:32], bus_req_i.writedata, wmask);
                `BIC_OFS_ROUTE0:  nxt_q.route[0] =
                                      merge(q_ff.route[0], bus_req_i.writedata, wmask);
                `BIC_OFS_ROUTE1:  nxt_q.route[1] =
                                      merge(q_ff.route[1], bus_req_i.writedata, wmask);
                `BIC_OFS_ROUTE2:  nxt_q.route[2] =
                                      merge(q_ff.route[2], bus_req_i.writedata, wmask);
                `BIC_OFS_STATUS:  stat_w1c = bus_req_i.writedata[1:0] & wmask[1:0];
                `BIC_OFS_MASK:    nxt_q.mask = 2'(merge({30'h0000_0000, q_ff.mask},
                                                        bus_req_i.writedata, wmask));
                default:          nxt_q.wait_rq = 1'b1;
            endcase
        end

        // A request arriving with its clear is kept: set wins over clear.
        nxt_q.prev = src_i;
        nxt_q.pend = ((q_ff.pend & ~sw_clr) | sw_set | hw_hit) & SRC_VALID;

        // Status bit per word: set by any enabled pending source in that word, held until written with 1.
        nxt_q.stat = (q_ff.stat & ~stat_w1c) | {|act[63:32], |act[31:0]};
        nxt_q.irq  = |(nxt_q.stat & nxt_q.mask);

        for (int i = 0; i < 12; i++) begin
            sel = q_ff.route[i / 4][i % 4 * `BIC_ROUTE_FLD_STRIDE +: `BIC_ROUTE_FLD_W];
            nxt_q.ext[i] = act[sel];
        end

        if (q_ff.locator[`BIC_LOC_IDENT_BIT]) begin
            if (q_ff.blink_cnt == BLINK_LAST) begin
                nxt_q.blink_cnt = 23'h00_0000;
                nxt_q.blink_ph  = ~q_ff.blink_ph;
            end else begin
                nxt_q.blink_cnt = q_ff.blink_cnt + 23'h00_0001;
            end
            nxt_q.led_red   = q_ff.blink_ph;
            nxt_q.led_green = ~q_ff.blink_ph;
        end else begin
            nxt_q.blink_cnt = 23'h00_0000;
            nxt_q.blink_ph  = 1'b0;
            nxt_q.led_red   = q_ff.irq;
            nxt_q.led_green = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q_ff         <= '0;
            q_ff.mask    <= `BIC_MASK_RST;
            q_ff.wait_rq <= 1'b1;
            q_ff.locator <= `BIC_WORD_RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign bus_rsp_o.waitrequest = q_ff.wait_rq;
    assign bus_rsp_o.readdata    = q_ff.rdata;
    assign host_irq_o            = q_ff.irq;
    assign ext_irq_o             = q_ff.ext;
    assign led_red_o             = q_ff.led_red;
    assign led_green_o           = q_ff.led_green;

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_wr(logic [7:0] a);
        bus_req_i.write && !q_ff.wait_rq && bus_req_i.address == a;
    endsequence

    sequence s_rd_fetch(logic [7:0] a);
        bus_req_i.read && q_ff.wait_rq && bus_req_i.address == a;
    endsequence

    // The red lamp shows the phase one cycle late, unless identify was dropped meanwhile.
    sequence s_blink_wrap;
        q_ff.locator[7] && q_ff.blink_cnt == BLINK_LAST;
    endsequence

    sequence s_bus_fetch;
        (bus_req_i.read || bus_req_i.write) && q_ff.wait_rq;
    endsequence

    a_ident_blink: assert property (
        s_blink_wrap
        |=> q_ff.blink_ph != $past(q_ff.blink_ph)
        ##1 (!$past(q_ff.locator[7]) || led_red_o == $past(q_ff.blink_ph)))
        else $error("identify blink phase did not swap");

    a_ident_stop: assert property (
        !q_ff.locator[7] |=> led_green_o && q_ff.blink_cnt == 23'h00_0000)
        else $error("leds not back to normal after identify off");

    a_route_gate: assert property (
        1'b1 |=> ext_irq_o[5] == $past(act[q_ff.route[1][13:8]]))
        else $error("external output does not follow routed enabled source");

    a_sw_request: assert property (
        s_wr(`BIC_OFS_PEND_LO) and (bus_req_i.writedata[0] && bus_req_i.byteenable[0])
        |=> q_ff.pend[0])
        else $error("software request did not set pending");

    a_clear_pend: assert property (
        s_wr(`BIC_OFS_CLR_LO) and (bus_req_i.writedata[3] && bus_req_i.byteenable[0]
        && !hw_hit[3]) |=> !q_ff.pend[3])
        else $error("clear did not remove pending request");

    a_edge_armed: assert property (
        !q_ff.lvl[1] && !q_ff.arm[1] && !q_ff.pend[1] && !sw_set[1] |=> !q_ff.pend[1])
        else $error("unarmed edge source became pending");

    a_edge_catch: assert property (
        !q_ff.lvl[2] && q_ff.arm[2] && !q_ff.pol[2] && q_ff.prev[2] && !src_i[2]
        |=> q_ff.pend[2])
        else $error("armed falling edge missed");

    a_level_sense: assert property (
        q_ff.lvl[4] && src_i[4] == q_ff.pol[4] |=> q_ff.pend[4])
        else $error("active level did not hold pending");

    a_summary_bit: assert property (
        s_rd_fetch(`BIC_OFS_PEND_LO) |=> bus_rsp_o.readdata[16] == $past(~|q_ff.pend[63:32]))
        else $error("summary bit does not reflect second pending word");

    a_option_word: assert property (
        s_rd_fetch(`BIC_OFS_OPTIONS) |=> !bus_rsp_o.waitrequest && bus_rsp_o.readdata == FW_INFO)
        else $error("option word read back wrong");

    a_host_irq: assert property (
        (|act[31:0]) && q_ff.mask[0] |-> ##2 host_irq_o)
        else $error("host interrupt not raised for enabled pending source");

    ////////////////////////////////////////////////////////////////////////////

    // Bus handshake: exactly one wait cycle, then waitrequest returns high.
    a_wait_single: assert property (
        s_bus_fetch
        |=> !bus_rsp_o.waitrequest)
        else $error("waitrequest did not drop after one wait cycle");

    a_wait_release: assert property (
        !bus_rsp_o.waitrequest
        |=> bus_rsp_o.waitrequest)
        else $error("waitrequest stayed low for more than one cycle");

    // Identify control and lamp behaviour.
    a_locator_write: assert property (
        s_wr(`BIC_OFS_LOCATOR) and (bus_req_i.byteenable == 4'hf)
        |=> q_ff.locator == $past(bus_req_i.writedata))
        else $error("locator word did not take the written value");

    a_ident_leds: assert property (
        q_ff.locator[7]
        |=> led_green_o != led_red_o)
        else $error("identify lamps not in opposite colours");

    a_blink_count: assert property (
        q_ff.locator[7] && q_ff.blink_cnt != BLINK_LAST
        |=> q_ff.blink_cnt == $past(q_ff.blink_cnt) + 23'h00_0001)
        else $error("blink counter did not advance");

    a_blink_hold: assert property (
        q_ff.locator[7] && q_ff.blink_cnt != BLINK_LAST
        |=> $stable(q_ff.blink_ph))
        else $error("blink phase swapped before its half period");

    a_red_normal: assert property (
        !q_ff.locator[7]
        |=> led_red_o == $past(q_ff.irq))
        else $error("red lamp does not follow host interrupt");

    // Enable, request, pending and clear.
    a_disabled_quiet: assert property (
        q_ff.en == 64'h0000_0000_0000_0000
        |=> (q_ff.stat & ~$past(q_ff.stat)) == 2'h0)
        else $error("status set with every source disabled");

    a_sw_request_hi: assert property (
        s_wr(`BIC_OFS_PEND_HI) and (bus_req_i.writedata[3] && bus_req_i.byteenable[0])
        |=> q_ff.pend[35])
        else $error("software request in high word did not set pending");

    a_pend_sticky: assert property (
        q_ff.pend[0] && !sw_clr[0]
        |=> q_ff.pend[0])
        else $error("pending request lost without a clear");

    a_clear_hi: assert property (
        s_wr(`BIC_OFS_CLR_HI) and (bus_req_i.writedata[3] && bus_req_i.byteenable[0]
        && !hw_hit[35]) |=> !q_ff.pend[35])
        else $error("clear did not remove high word request");

    // Edge and level detection, and the pending summary bit.
    a_edge_rise: assert property (
        !q_ff.lvl[5] && q_ff.arm[5] && q_ff.pol[5] && !q_ff.prev[5] && src_i[5]
        |=> q_ff.pend[5])
        else $error("armed rising edge missed");

    a_level_idle: assert property (
        q_ff.lvl[6] && src_i[6] != q_ff.pol[6] && !q_ff.pend[6] && !sw_set[6]
        |=> !q_ff.pend[6])
        else $error("inactive level source became pending");

    a_summary_busy: assert property (
        s_rd_fetch(`BIC_OFS_PEND_LO) and (|q_ff.pend[63:32])
        |=> !bus_rsp_o.readdata[16])
        else $error("summary bit set while second word is pending");

    // External routing.
    a_route_first: assert property (
        1'b1
        |=> ext_irq_o[0] == $past(act[q_ff.route[0][5:0]]))
        else $error("first external output does not follow its select");

    a_route_last: assert property (
        1'b1
        |=> ext_irq_o[11] == $past(act[q_ff.route[2][29:24]]))
        else $error("last external output does not follow its select");

    a_route_write: assert property (
        s_wr(`BIC_OFS_ROUTE2) and (bus_req_i.byteenable == 4'hf)
        |=> q_ff.route[2] == $past(bus_req_i.writedata))
        else $error("routing word did not take the written value");

    // Host interrupt gating by status and mask.
    a_irq_drop: assert property (
        act == 64'h0000_0000_0000_0000 && (q_ff.stat & q_ff.mask) == 2'h0
        |=> !host_irq_o)
        else $error("host interrupt high with nothing pending and enabled");

    a_mask_gate: assert property (
        q_ff.mask == 2'h0 && !bus_req_i.write
        |=> !host_irq_o)
        else $error("host interrupt high while fully masked");

endmodule : bic_irq_ctrl

// File: tb/bic_src_model.sv
/*
 * Model of the interrupt source lines that face the block.
 * Assumes the bench sets the wanted levels and the lines change on the clock.
 */
`timescale 1ns/1ps

module bic_src_model (
    input  wire logic        clk_sys_i,
    input  wire logic [63:0] level_i,
    output logic      [63:0] src_o
);
    // Sources are synchronous, so each line moves just after a rising edge.
    always_ff @(posedge clk_sys_i) begin
        src_o <= level_i;
    end
endmodule : bic_src_model

// File: tb/bic_irq_ctrl_tb_top.sv
/*
 * Self-checking bench of the interrupt control block.
 * Assumes one wait cycle per bus access and a shortened blink count.
 */
`timescale 1ns/1ps
`include "bic_defs.svh"

module bic_irq_ctrl_tb_top;
    import bic_pkg::*;
    localparam logic [31:0] FW = 32'h0000_00a5;  // Arbitrary value.
    localparam int          HALF = 8;
    logic        clk_sys_i;
    logic        reset_n_i;
    bic_av_req_t req;
    bic_av_rsp_t rsp;
    logic [63:0] t_src;
    logic [63:0] src;
    logic        host_irq;
    logic [11:0] ext;
    logic        red;
    logic        green;
    int          fail_count;
    int          n_tests;

    bic_src_model PART (.clk_sys_i(clk_sys_i), .level_i(t_src), .src_o(src));
    bic_irq_ctrl #(.BLINK_HALF_CYC(HALF), .FW_INFO(FW)) DUT (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .bus_req_i(req), .bus_rsp_o(rsp),
        .src_i(src), .host_irq_o(host_irq), .ext_irq_o(ext), .led_red_o(red),
        .led_green_o(green));

    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : tick

    // One access: held until waitrequest is seen low at a rising edge.
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        req.read       <= rd;
        req.write      <= ~rd;
        req.address    <= a;
        req.byteenable <= 4'hf;
        req.writedata  <= d;
        @(posedge clk_sys_i);
        while (rsp.waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge clk_sys_i);
        end
        chk("waitrequest", 32'(n >= 50), 32'h0);
        q = rsp.readdata;
        req.read  <= 1'b0;
        req.write <= 1'b0;
        @(posedge clk_sys_i);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b1, a, 32'h0, q);
        chk($sformatf("reg %h", a), q, exp);
    endtask : rdc

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_map;
        rdc(`BIC_OFS_OPTIONS, FW);
        wr(`BIC_OFS_OPTIONS, 32'hffff_ffff);
        rdc(`BIC_OFS_OPTIONS, FW);
        rdc(8'h0c, 32'h0);
        rdc(`BIC_OFS_PEND_LO, 32'h0001_0000);
        rdc(`BIC_OFS_MASK, 32'h3);
        rdc(`BIC_OFS_LOCATOR, 32'h0);
    endtask : t_reset_map

    task automatic t_soft_req;
        wr(`BIC_OFS_PEND_HI, 32'h8);
        rdc(`BIC_OFS_PEND_HI, 32'h8);
        rdc(`BIC_OFS_PEND_LO, 32'h0);
        chk("host_irq", host_irq, 1'b0);
        wr(`BIC_OFS_EN_HI, 32'h8);
        tick(3);
        chk("host_irq", host_irq, 1'b1);
        wr(`BIC_OFS_MASK, 32'h0);
        tick(2);
        chk("host_irq", host_irq, 1'b0);
        wr(`BIC_OFS_MASK, 32'h3);
        wr(`BIC_OFS_CLR_HI, 32'h8);
        wr(`BIC_OFS_STATUS, 32'h3);
        tick(3);
        chk("host_irq", host_irq, 1'b0);
        rdc(`BIC_OFS_PEND_HI, 32'h0);
        rdc(`BIC_OFS_PEND_LO, 32'h0001_0000);
    endtask : t_soft_req

    task automatic t_level;
        wr(`BIC_OFS_LVL_LO, 32'h1);
        tick(2);
        rdc(`BIC_OFS_PEND_LO, 32'h0001_0001);
        t_src[0] <= 1'b1;
        tick(2);
        wr(`BIC_OFS_CLR_LO, 32'h1);
        rdc(`BIC_OFS_PEND_LO, 32'h0001_0000);
        wr(`BIC_OFS_POL_LO, 32'h1);
        tick(2);
        rdc(`BIC_OFS_PEND_LO, 32'h0001_0001);
        wr(`BIC_OFS_LVL_LO, 32'h0);
        wr(`BIC_OFS_POL_LO, 32'h2);
        t_src[0] <= 1'b0;
        tick(2);
        wr(`BIC_OFS_CLR_LO, 32'h1);
        t_src[1] <= 1'b1;
        tick(3);
        rdc(`BIC_OFS_PEND_LO, 32'h0001_0000);
        wr(`BIC_OFS_ARM_LO, 32'h2);
        t_src[1] <= 1'b0;
        tick(3);
        rdc(`BIC_OFS_PEND_LO, 32'h0001_0000);
        t_src[1] <= 1'b1;
        tick(3);
        rdc(`BIC_OFS_PEND_LO, 32'h0001_0002);
    endtask : t_level

    task automatic t_route;
        wr(`BIC_OFS_ROUTE0, 32'h0001_0100);
        wr(`BIC_OFS_ROUTE2, 32'h0100_0000);
        chk("ext", 32'(ext), 32'h0);
        wr(`BIC_OFS_EN_LO, 32'h2);
        tick(2);
        chk("ext", 32'(ext), 32'h806);
        wr(`BIC_OFS_CLR_LO, 32'h2);
        tick(2);
        chk("ext", 32'(ext), 32'h0);
    endtask : t_route

    task automatic t_blink;
        int c;
        c = 0;
        wr(`BIC_OFS_LOCATOR, 32'h80);
        @(negedge clk_sys_i);
        while (red !== 1'b1 && c < 40) begin
            c++;
            @(negedge clk_sys_i);
        end
        chk("green", green, 1'b0);
        c = 0;
        while (red === 1'b1 && c < 40) begin
            c++;
            @(negedge clk_sys_i);
        end
        chk("half period", c, HALF);
        chk("green", green, 1'b1);
        @(posedge clk_sys_i);
        wr(`BIC_OFS_STATUS, 32'h3);
        wr(`BIC_OFS_LOCATOR, 32'h0);
        tick(3);
        @(negedge clk_sys_i);
        chk("green", green, 1'b1);
        chk("red", red, 1'b0);
        chk("host_irq", host_irq, 1'b0);
    endtask : t_blink

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        fail_count = 0;
        n_tests    = 0;
        req        = '0;
        t_src      = 64'h0;
        reset_n_i  = 1'b0;
        tick(2);
        reset_n_i <= 1'b1;
        tick(1);
        t_reset_map();
        t_soft_req();
        t_level();
        t_route();
        t_blink();
        complete_run();
    end

    initial begin
        #2000000;
        fail_count++;
        complete_run();
    end
endmodule : bic_irq_ctrl_tb_top
